// ### pkg/npps_pkg.sv
// constants and carrier types of the page program sequencer
package npps_pkg;
  localparam logic [7:0] NPPS_OP_PP     = 8'h02;
  localparam logic [7:0] NPPS_OP_QPP    = 8'h32;
  localparam logic [5:0] NPPS_OP_BITS   = 6'h08;
  localparam logic [5:0] NPPS_HDR_BITS  = 6'h20;
  localparam int         NPPS_PAGE_BYTES = 256;
  localparam int         NPPS_CLK_NS    = 25;
  // program_cycle_time in ns, plain default
  localparam int         NPPS_TPP_NS    = 100000;
  localparam int         NPPS_TPP_CYC   = (NPPS_TPP_NS + NPPS_CLK_NS - 1) / NPPS_CLK_NS;
  localparam logic       NPPS_WEL_RST   = 1'b0;
  localparam logic       NPPS_WIP_RST   = 1'b0;

  typedef enum logic [1:0] {
    NPPS_IDLE    = 2'b00,
    NPPS_COLLECT = 2'b01,
    NPPS_CLOSE   = 2'b10,
    NPPS_PROG    = 2'b11
  } npps_state_e;

  typedef struct packed {
    logic quad_enable_bit;
    logic block_protect_bit4;
    logic block_protect_bit3;
    logic block_protect_bit2;
    logic block_protect_bit1;
    logic block_protect_bit0;
  } npps_cfg_s;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  data;
  } npps_word_s;
endpackage : npps_pkg

// ### verification/npps_host_model.sv
// host controller model: drives select, serial clock and the four io lines
module npps_host_model (
  // serial link
  output logic       sck_o,
  output logic       cs_n_o,
  output logic [3:0] io_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    io_o = 4'h0;
  end

  // 80 ns link clock, only toggles inside a frame
  task automatic put(input logic [3:0] v);
    io_o = v;
    #40 sck_o = 1'b1;
    #40 sck_o = 1'b0;
  endtask : put

  task automatic frame(input logic [31:0] hdr, input logic [7:0] d[$], input logic quad,
                       input int cut);
    int b;
    cs_n_o = 1'b0;
    #20;
    for (b = 31; b >= 0; b--) put({3'h0, hdr[b]});
    foreach (d[j]) begin
      if (quad) begin
        put(d[j][7:4]);
        put(d[j][3:0]);
      end else begin
        for (b = 7; b >= 0; b--) put({3'h0, d[j][b]});
      end
    end
    // partial byte only when a scenario asks for it
    for (b = 0; b < cut; b++) put(4'h5);
    #20 cs_n_o = 1'b1;
    // released lines must not keep showing the last value
    io_o = ~io_o;
  endtask : frame
endmodule : npps_host_model

// ### verification/npps_sequencer_assertions.sv
// port-level assertions of the page program sequencer
module npps_sequencer_assertions
  import npps_pkg::*;
(
  // watched ports
  input wire logic       sys_clk_i,
  input wire logic       rst_n_i,
  input wire logic       cs_n_i,
  input wire logic       prog_ready_i,
  input wire logic       prog_valid_o,
  input wire npps_word_s prog_word_o,
  input wire logic       write_in_progress_flag_o,
  input wire logic       write_enable_latch_o,
  input wire logic       cmd_abort_o
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_start_on_select: assert property (
      $rose(write_in_progress_flag_o) |-> cs_n_i && $past(cs_n_i))
    else $error("program cycle began with select low");
  a_wel_cleared: assert property (
      $rose(write_in_progress_flag_o) |-> !write_enable_latch_o)
    else $error("latch still set at cycle start");
  a_busy_min: assert property (
      $rose(write_in_progress_flag_o) |=> write_in_progress_flag_o [*8])
    else $error("progress flag dropped too early");
  a_abort_pulse: assert property (cmd_abort_o |=> !cmd_abort_o)
    else $error("abort longer than one cycle");
  a_abort_idle: assert property (cmd_abort_o |-> !write_in_progress_flag_o)
    else $error("abort while a cycle runs");
  a_word_held: assert property (
      prog_valid_o && !prog_ready_i |=> prog_valid_o && $stable(prog_word_o))
    else $error("stalled word changed or vanished");
  a_words_in_cycle: assert property (prog_valid_o |-> write_in_progress_flag_o)
    else $error("array write outside program cycle");
  a_same_page: assert property (
      prog_valid_o && prog_ready_i ##1 prog_valid_o |->
      prog_word_o.addr[23:8] == $past(prog_word_o.addr[23:8])
      && prog_word_o.addr[7:0] > $past(prog_word_o.addr[7:0]))
    else $error("word left the page or offsets not ascending");
  a_wel_held: assert property (
      write_in_progress_flag_o && !write_enable_latch_o |=> !write_enable_latch_o)
    else $error("latch set during program cycle");
endmodule : npps_sequencer_assertions

bind npps_sequencer npps_sequencer_assertions u_chk (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .prog_ready_i(prog_ready_i),
  .prog_valid_o(prog_valid_o), .prog_word_o(prog_word_o),
  .write_in_progress_flag_o(write_in_progress_flag_o),
  .write_enable_latch_o(write_enable_latch_o), .cmd_abort_o(cmd_abort_o));

// ### verification/npps_sequencer_bench.sv
// self-checking bench of the page program sequencer
module npps_sequencer_bench
  import npps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       sck, cs_n, wel_set = 1'b0, wel_clr = 1'b0, ready = 1'b0;
  logic       valid, write_in_progress_flag, write_enable_latch, abort, ab_seen;
  logic [3:0] io;
  npps_cfg_s  cfg = '0;
  npps_word_s word;
  npps_word_s exp_q[$];
  int         fail_count = 0;
  int         checks = 0;
  int         tn = 0;

  always #12.5 sys_clk = ~sys_clk;

  npps_host_model host (.sck_o(sck), .cs_n_o(cs_n), .io_o(io));
  npps_sequencer #(.TPP_CYC(20)) uut (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .sck_i(sck), .cs_n_i(cs_n),
    .io_line_0_i(io[0]), .io_line_1_i(io[1]), .io_line_2_i(io[2]), .io_line_3_i(io[3]),
    .cfg_i(cfg), .wel_set_i(wel_set), .wel_clr_i(wel_clr), .prog_ready_i(ready),
    .prog_valid_o(valid), .prog_word_o(word), .write_in_progress_flag_o(write_in_progress_flag),
    .write_enable_latch_o(write_enable_latch), .cmd_abort_o(abort));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  // random stalls by the array side
  always @(posedge sys_clk) begin
    #2 ready = ($urandom_range(0, 3) != 0);
  end

  always @(posedge sys_clk) begin
    if (abort === 1'b1) ab_seen = 1'b1;
    if (valid === 1'b1 && ready === 1'b1) begin
      if (exp_q.size() == 0) check("extra word", 32'h1, 32'h0);
      else check("word", word, exp_q.pop_front());
    end
  end

  task automatic run(input logic [7:0] op, input logic [7:0] off, input int n, input int cut,
                     input logic we, input logic ok);
    logic [7:0]  d[$];
    int          mem[256];
    int          k;
    logic [15:0] pg;
    pg = 16'($urandom);
    for (k = 0; k < 256; k++) mem[k] = -1;
    for (k = 0; k < n; k++) begin
      d.push_back(8'($urandom));
      mem[(off + k) % 256] = d[k];
    end
    if (ok) for (k = 0; k < 256; k++) if (mem[k] >= 0) exp_q.push_back({pg, 8'(k), 8'(mem[k])});
    @(posedge sys_clk);
    #2 wel_set = we;
    wel_clr = !we;
    @(posedge sys_clk);
    #2 wel_set = 1'b0;
    wel_clr = 1'b0;
    ab_seen = 1'b0;
    @(posedge sys_clk);
    #2 check("latch", write_enable_latch, we);
    host.frame({op, pg, off}, d, op == NPPS_OP_QPP, cut);
    for (k = 0; k < 30 && write_in_progress_flag !== 1'b1 && ab_seen !== 1'b1; k++) @(posedge sys_clk);
    if (k == 30) begin
      check("decision timeout", 32'h1, 32'h0);
      summarize();
    end
    #2 check("progress", write_in_progress_flag, ok);
    check("abort", ab_seen, !ok);
    if (ok) check("latch after", write_enable_latch, 1'b0);
    for (k = 0; k < 2000 && write_in_progress_flag !== 1'b0; k++) @(posedge sys_clk);
    if (k == 2000) begin
      check("cycle timeout", 32'h1, 32'h0);
      summarize();
    end
    check("left", exp_q.size(), 0);
    tn++;
    $display("test %0d done", tn);
  endtask : run

  initial begin
    void'($urandom(32'h20a6));
    repeat (12) @(posedge sys_clk);
    #2 rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    run(NPPS_OP_PP, 8'h00, 4, 0, 1'b0, 1'b0);
    run(NPPS_OP_PP, 8'hf0, 20, 0, 1'b1, 1'b1);
    run(NPPS_OP_PP, 8'h10, 260, 0, 1'b1, 1'b1);
    run(NPPS_OP_QPP, 8'h00, 5, 0, 1'b1, 1'b0);
    cfg.quad_enable_bit = 1'b1;
    run(NPPS_OP_QPP, 8'hfe, 6, 0, 1'b1, 1'b1);
    run(NPPS_OP_PP, 8'h40, 3, 3, 1'b1, 1'b0);
    run(NPPS_OP_PP, 8'h40, 0, 0, 1'b1, 1'b0);
    cfg.block_protect_bit4 = 1'b1;
    run(NPPS_OP_PP, 8'h08, 2, 0, 1'b1, 1'b0);
    summarize();
  end
endmodule : npps_sequencer_bench

// ### verilog/npps_sequencer.sv
// page program sequencer: serial link capture, page buffer, program cycle
// Notes on behaviour
// - program opcode needs write enable latch set
// - data past page end wraps to offset zero
// - over 256 bytes keeps last 256 only
// - short page writes leave other bytes untouched
// - select must rise on byte boundary, else abandon
// - select rise starts timed program cycle
// - progress flag high during cycle, low after
// - write enable latch cleared before cycle ends
// - protected target page is never programmed
// - quad program needs quad enable bit set
module npps_sequencer
  import npps_pkg::*;
#(
  parameter int TPP_CYC = NPPS_TPP_CYC
) (
  // system side
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // serial link
  input  wire logic       sck_i,
  input  wire logic       cs_n_i,
  input  wire logic       io_line_0_i,
  input  wire logic       io_line_1_i,
  input  wire logic       io_line_2_i,
  input  wire logic       io_line_3_i,
  // status bits and latch control
  input  wire npps_cfg_s  cfg_i,
  input  wire logic       wel_set_i,
  input  wire logic       wel_clr_i,
  // array write port
  input  wire logic       prog_ready_i,
  output logic            prog_valid_o,
  output npps_word_s      prog_word_o,
  // status
  output logic            write_in_progress_flag_o,
  output logic            write_enable_latch_o,
  output logic            cmd_abort_o
);

  if (TPP_CYC < 1) begin : g_chk
    $error("TPP_CYC must be at least one cycle");
  end

  ////////////////////////////////////////////////////////////////////////
  // link domain, clocked by the serial clock
  logic        fresh_r;
  logic [5:0]  cnt_r;
  logic [2:0]  sub_r;
  logic [7:0]  op_r;
  logic [23:0] adr_r;
  logic [7:0]  sh_r;
  logic [7:0]  byte_r;
  logic        tgl_r;
  logic [5:0]  c_eff;
  logic [2:0]  s_eff;
  logic        quad;
  logic [7:0]  sh_nxt;
  logic [2:0]  sub_nxt;
  logic        byte_done;

  // preset by select high so every frame starts its counts from zero
  always_ff @(posedge sck_i or posedge cs_n_i or negedge rst_n_i) begin
    if (!rst_n_i || cs_n_i) begin
      fresh_r <= 1'b1;
    end else begin
      fresh_r <= 1'b0;
    end
  end

  always_comb begin
    c_eff     = fresh_r ? 6'h00 : cnt_r;
    s_eff     = fresh_r ? 3'h0 : sub_r;
    quad      = (op_r == NPPS_OP_QPP);
    sh_nxt    = quad ? {sh_r[3:0], io_line_3_i, io_line_2_i, io_line_1_i, io_line_0_i}
                     : {sh_r[6:0], io_line_0_i};
    sub_nxt   = s_eff + (quad ? 3'h4 : 3'h1);
    byte_done = (c_eff == NPPS_HDR_BITS) && (sub_nxt == 3'h0);
  end

  // header shift, msb first on rising serial clock
  always_ff @(posedge sck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 6'h00;
      op_r  <= 8'h00;
      adr_r <= 24'h00_0000;
    end else if (!cs_n_i) begin
      if (c_eff != NPPS_HDR_BITS) begin
        cnt_r <= c_eff + 6'h01;
      end
      if (c_eff < NPPS_OP_BITS) begin
        op_r <= {op_r[6:0], io_line_0_i};
      end else if (c_eff < NPPS_HDR_BITS) begin
        adr_r <= {adr_r[22:0], io_line_0_i};
      end
    end
  end

  // data bytes; sub counts bit slots so a short last byte stays visible
  always_ff @(posedge sck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sub_r  <= 3'h0;
      sh_r   <= 8'h00;
      byte_r <= 8'h00;
      tgl_r  <= 1'b0;
    end else if (!cs_n_i) begin
      if (c_eff != NPPS_HDR_BITS) begin
        sub_r <= 3'h0;
      end else begin
        sub_r <= sub_nxt;
        sh_r  <= sh_nxt;
        if (byte_done) begin
          byte_r <= sh_nxt;
          tgl_r  <= ~tgl_r;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // crossing: select level and byte toggle through two flops each
  logic [1:0] cs_sync_r;
  logic [1:0] tgl_sync_r;
  logic       cs_d_r;
  logic       tgl_d_r;
  logic       cs_fall;
  logic       cs_rise;
  logic       byte_ev;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_sync_r  <= 2'b11;
      tgl_sync_r <= 2'b00;
      cs_d_r     <= 1'b1;
      tgl_d_r    <= 1'b0;
    end else begin
      cs_sync_r  <= {cs_sync_r[0], cs_n_i};
      tgl_sync_r <= {tgl_sync_r[0], tgl_r};
      cs_d_r     <= cs_sync_r[1];
      tgl_d_r    <= tgl_sync_r[1];
    end
  end

  assign cs_fall = cs_d_r && !cs_sync_r[1];
  assign cs_rise = !cs_d_r && cs_sync_r[1];
  assign byte_ev = tgl_d_r != tgl_sync_r[1];

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  npps_state_e                state_r;
  logic [7:0]                 pbuf_r [NPPS_PAGE_BYTES];
  logic [NPPS_PAGE_BYTES-1:0] mask_r;
  logic [15:0]                page_r;
  logic [7:0]                 idx_r;
  logic                       any_r;
  logic                       close_r;
  logic [31:0]                tmr_r;
  logic [8:0]                 scan_r;
  logic                       wel_r;
  logic                       wip_r;
  logic                       abort_r;
  logic                       is_prog;
  logic                       accept;
  logic                       done;
  logic                       push;
  logic                       pop;
  npps_word_s                 push_w;
  npps_word_s                 tail_r;
  logic                       tail_v_r;

  // bp4 or all-ones level guards everything, level zero guards nothing; else top or bottom slice
  function automatic logic prot_f(input npps_cfg_s c, input logic [15:0] pg);
    logic [2:0]  lvl;
    int          k;
    logic [15:0] top;
    lvl = {c.block_protect_bit2, c.block_protect_bit1, c.block_protect_bit0};
    k   = 7 - int'(lvl);
    top = pg >> (16 - k);
    if (c.block_protect_bit4 || lvl == 3'h7) begin
      prot_f = 1'b1;
    end else if (lvl == 3'h0) begin
      prot_f = 1'b0;
    end else if (c.block_protect_bit3) begin
      prot_f = (top == 16'h0000);
    end else begin
      prot_f = (top == 16'((1 << k) - 1));
    end
  endfunction : prot_f

  // link header regs are read only once data has flowed or select is high
  assign is_prog = (op_r == NPPS_OP_PP) || (op_r == NPPS_OP_QPP);
  assign accept  = is_prog && wel_r
                   && (op_r != NPPS_OP_QPP || cfg_i.quad_enable_bit)
                   && any_r && (sub_r == 3'h0)
                   && !prot_f(cfg_i, page_r);
  assign done    = (tmr_r == 32'h0000_0000) && scan_r[8] && !prog_valid_o;
  assign push    = (state_r == NPPS_PROG) && !scan_r[8] && mask_r[scan_r[7:0]] && !tail_v_r;
  assign pop     = prog_valid_o && prog_ready_i;
  assign push_w  = '{addr: {page_r, scan_r[7:0]}, data: pbuf_r[scan_r[7:0]]};

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= NPPS_IDLE;
      close_r <= 1'b0;
      abort_r <= 1'b0;
    end else begin
      abort_r <= 1'b0;
      case (state_r)
        NPPS_IDLE: begin
          if (cs_fall) begin
            state_r <= NPPS_COLLECT;
          end
        end
        NPPS_COLLECT: begin
          if (cs_rise) begin
            state_r <= NPPS_CLOSE;
            close_r <= 1'b0;
          end
        end
        NPPS_CLOSE: begin
          // extra cycle lets a last byte toggle lagging select land first
          close_r <= 1'b1;
          if (close_r) begin
            if (accept) begin
              state_r <= NPPS_PROG;
            end else begin
              state_r <= NPPS_IDLE;
              abort_r <= is_prog;
            end
          end
        end
        NPPS_PROG: begin
          if (done) begin
            state_r <= NPPS_IDLE;
          end
        end
        default: state_r <= NPPS_IDLE;
      endcase
    end
  end

  // page buffer: offset pointer wraps inside the page
  always_ff @(posedge sys_clk_i) begin
    if (byte_ev && (state_r == NPPS_COLLECT || state_r == NPPS_CLOSE)) begin
      pbuf_r[any_r ? idx_r : adr_r[7:0]] <= byte_r;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_r <= '0;
      page_r <= 16'h0000;
      idx_r  <= 8'h00;
      any_r  <= 1'b0;
    end else if (state_r == NPPS_IDLE && cs_fall) begin
      mask_r <= '0;
      any_r  <= 1'b0;
    end else if (byte_ev && (state_r == NPPS_COLLECT || state_r == NPPS_CLOSE)) begin
      any_r <= 1'b1;
      if (any_r) begin
        mask_r[idx_r] <= 1'b1;
        idx_r         <= idx_r + 8'h01;
      end else begin
        page_r             <= adr_r[23:8];
        mask_r[adr_r[7:0]] <= 1'b1;
        idx_r              <= adr_r[7:0] + 8'h01;
      end
    end
  end

  // cycle timer and progress flag
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tmr_r  <= 32'h0000_0000;
      scan_r <= 9'h000;
      wip_r  <= NPPS_WIP_RST;
    end else if (state_r == NPPS_CLOSE && close_r && accept) begin
      tmr_r  <= 32'(TPP_CYC - 1);
      scan_r <= 9'h000;
      wip_r  <= 1'b1;
    end else if (state_r == NPPS_PROG) begin
      if (tmr_r != 32'h0000_0000) begin
        tmr_r <= tmr_r - 32'h0000_0001;
      end
      if (!scan_r[8] && (push || !mask_r[scan_r[7:0]])) begin
        scan_r <= scan_r + 9'h001;
      end
      if (done) begin
        wip_r <= 1'b0;
      end
    end
  end

  // set beats a host clear outside a cycle, but never the clear at cycle start
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wel_r <= NPPS_WEL_RST;
    end else if (wel_set_i && !wip_r && !(state_r == NPPS_CLOSE && close_r && accept)) begin
      wel_r <= 1'b1;
    end else if (wel_clr_i || (state_r == NPPS_CLOSE && close_r && accept)) begin
      wel_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two-entry buffer toward the array; a stalled array halts the scan
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prog_valid_o <= 1'b0;
      prog_word_o  <= '0;
      tail_v_r     <= 1'b0;
      tail_r       <= '0;
    end else if (pop) begin
      if (tail_v_r) begin
        prog_word_o <= tail_r;
        tail_v_r    <= push;
        if (push) begin
          tail_r <= push_w;
        end
      end else begin
        prog_valid_o <= push;
        if (push) begin
          prog_word_o <= push_w;
        end
      end
    end else if (push) begin
      if (!prog_valid_o) begin
        prog_valid_o <= 1'b1;
        prog_word_o  <= push_w;
      end else begin
        tail_v_r <= 1'b1;
        tail_r   <= push_w;
      end
    end
  end

  assign write_in_progress_flag_o = wip_r;
  assign write_enable_latch_o     = wel_r;
  assign cmd_abort_o              = abort_r;

endmodule : npps_sequencer
